// ### hw/vui_utility_irq.sv
// utility interrupt handler, VMEbus interrupter, bus error cause and global CSR base select
// Operation
// - any reset clears all enable bits
// - request CPU acknowledge only when master enable set
// - sources use fixed local levels one to seven
// - enable bits 1 and 5 gate attention sources
// - enable bits 2 and 4 gate location monitors
// - enable bit 3 gives level 3 after IACK
// - enable bit 7 gives level 7 on write error
// - acknowledge vector low bits follow CPU acknowledge level input
// - normal vector read returns offset in low bits
// - source identifier equals source level, one to seven
// - vector base bits 3-7 writable, cleared by reset
// - level field selects which VMEbus IRQ line drives
// - nonzero level drives IRQ, cleared on matching IACK
// - IACK supplies status byte, reset value 0F
// - reading cause register clears all its bits
// - newest cause bit clears all other cause bits
// - cause bits for local, access and bus errors
// - foreign global timeouts never set cause bit 2
// - base gives short address bits 4-7, A08-A15 zero
// - base F disables response, monitors and attention
// - remote sets low attention, CPU write-one clears
// - monitor zero access clears flag, requests level 2
`timescale 1ns/1ps
module vui_utility_irq
   import vui_pkg::*;
(
   input wire logic REF_CLK,
   input wire logic RST_B,
   input wire logic LOCAL_RESET,
   input wire logic CPU_SEL,
   input wire logic CPU_WR,
   input wire logic [31:0] CPU_ADDR,
   input wire logic [7:0] CPU_WDATA,
   input wire logic CPU_IACK,
   input wire logic [2:0] CPU_IACK_LEVEL,
   output logic [7:0] CPU_RDATA,
   output logic CPU_ACK,
   input wire logic MASTER_IRQ_EN,
   output logic LOCAL_IRQ_REQ,
   output logic [2:0] LOCAL_IRQ_LEVEL,
   input wire logic VME_SET_LOW_ATTN,
   input wire logic VME_SET_HIGH_ATTN,
   input wire logic CLEAR_LOW_ATTN,
   input wire logic CLEAR_HIGH_ATTN,
   output logic [1:0] ATTN_BITS,
   input wire logic VME_MON0_HIT,
   input wire logic VME_MON1_HIT,
   input wire logic MON0_REARM,
   input wire logic MON1_REARM,
   output logic [1:0] MON_FLAGS,
   input wire logic SYSFAIL_ACTIVE,
   input wire logic POSTED_WR_BERR,
   input wire logic LOCAL_TIMEOUT,
   input wire logic VME_ACCESS_TIMEOUT,
   input wire logic VME_BERR_OWN,
   input wire vui_vme_iack_type VME_IACK,
   output logic VME_IACK_MATCH,
   output logic [7:1] VME_IRQ_OE,
   output logic [7:0] VME_STATUS_ID,
   input wire logic VME_SHORT_SEL,
   input wire logic [15:0] VME_SHORT_ADDR,
   output logic GLOBAL_CSR_SET_HIT,
   output logic [2:0] GLOBAL_CSR_SET_REG_SEL
);

   logic [7:1] enable_reg;
   logic [4:0] vec_base_reg;
   logic [2:0] level_reg;
   logic [7:0] status_id_reg;
   vui_cause_type cause_reg;
   logic [3:0] global_csr_set_base_reg;
   logic low_attn_reg;
   logic high_attn_reg;
   logic mon0_hit_reg;
   logic mon1_hit_reg;
   logic ack_done_reg;
   logic wp_err_reg;
   logic [7:1] pending;
   logic [7:1] active;
   logic global_csr_set_live;
   logic rd_take;
   logic wr_take;
   logic local_ack;
   logic [2:0] irq_level_next;
   logic [7:0] rdata_next;

   // highest set level of a seven-bit request vector, zero if none
   function automatic logic [2:0] vui_top_level(input logic [7:1] req);
      logic [2:0] lvl;
      lvl = 3'h0;
      for (int i = 1; i <= 7; i++)
      begin
         if (req[i])
         begin
            lvl = 3'(i);
         end
      end
      return lvl;
   endfunction

   // register strobes and the local acknowledge cycle
   assign wr_take = CPU_SEL & CPU_WR & ~CPU_IACK;
   assign rd_take = CPU_SEL & ~CPU_WR & ~CPU_IACK;
   assign local_ack = CPU_SEL & CPU_IACK;

   // global CSR window decode in short I/O space
   assign global_csr_set_live = (global_csr_set_base_reg != VUI_GLOBAL_CSR_SET_OFF);
   assign GLOBAL_CSR_SET_HIT = VME_SHORT_SEL & global_csr_set_live &
      (VME_SHORT_ADDR[15:VUI_SHORT_HIGH_LSB] == VUI_SHORT_HIGH_ZERO) &
      (VME_SHORT_ADDR[7:VUI_SHORT_BASE_LSB] == global_csr_set_base_reg);
   assign GLOBAL_CSR_SET_REG_SEL = VME_SHORT_ADDR[3:VUI_SHORT_REG_LSB];

   // pending vector indexed by fixed level
   assign pending[VUI_LVL_LOW_ATTN] = low_attn_reg;
   assign pending[VUI_LVL_MON0] = mon0_hit_reg;
   assign pending[VUI_LVL_ACK_DONE] = ack_done_reg;
   assign pending[VUI_LVL_MON1] = mon1_hit_reg;
   assign pending[VUI_LVL_HIGH_ATTN] = high_attn_reg;
   assign pending[VUI_LVL_SYSFAIL] = SYSFAIL_ACTIVE;
   assign pending[VUI_LVL_WP_BERR] = wp_err_reg;
   assign active = pending & enable_reg;
   assign irq_level_next = MASTER_IRQ_EN ? vui_top_level(active) : 3'h0;

   // VMEbus interrupter outputs
   assign VME_IACK_MATCH = VME_IACK.hit & (level_reg != 3'h0) &
      (VME_IACK.level == level_reg);
   assign VME_STATUS_ID = status_id_reg;
   assign LOCAL_IRQ_REQ = (LOCAL_IRQ_LEVEL != 3'h0);
   assign ATTN_BITS = {high_attn_reg, low_attn_reg};
   assign MON_FLAGS = {~mon1_hit_reg, ~mon0_hit_reg};

   // software enable mask and vector base, cleared by any reset
   always_ff @(posedge REF_CLK or negedge RST_B)
   begin
      if (!RST_B)
      begin
         enable_reg <= VUI_RST_ENABLE;
         vec_base_reg <= VUI_RST_VEC_BASE;
      end
      else if (LOCAL_RESET)
      begin
         enable_reg <= VUI_RST_ENABLE;
         vec_base_reg <= VUI_RST_VEC_BASE;
      end
      else if (wr_take)
      begin
         if (CPU_ADDR == VUI_OFS_ENABLE)
         begin
            enable_reg <= CPU_WDATA[7:VUI_ENABLE_LSB];
         end
         if (CPU_ADDR == VUI_OFS_VECTOR)
         begin
            vec_base_reg <= CPU_WDATA[7:VUI_VEC_BASE_LSB];
         end
      end
   end

   // interrupter level, status byte and global CSR base, system reset only
   always_ff @(posedge REF_CLK or negedge RST_B)
   begin
      if (!RST_B)
      begin
         level_reg <= VUI_RST_LEVEL;
         status_id_reg <= VUI_RST_STATUS_ID;
         global_csr_set_base_reg <= VUI_RST_GLOBAL_CSR_SET_BASE;
      end
      else
      begin
         if (VME_IACK_MATCH)
         begin
            level_reg <= 3'h0;
         end
         else if (wr_take && CPU_ADDR == VUI_OFS_LEVEL)
         begin
            level_reg <= CPU_WDATA[2:0];
         end
         if (wr_take && CPU_ADDR == VUI_OFS_STATUS_ID)
         begin
            status_id_reg <= CPU_WDATA;
         end
         if (wr_take && CPU_ADDR == VUI_OFS_GLOBAL_CSR_SET_BASE)
         begin
            global_csr_set_base_reg <= CPU_WDATA[3:0];
         end
      end
   end

   // one-hot IRQ drive from the level field
   always_ff @(posedge REF_CLK or negedge RST_B)
   begin
      if (!RST_B)
      begin
         VME_IRQ_OE <= 7'h00;
      end
      else
      begin
         for (int n = 1; n <= 7; n++)
         begin
            VME_IRQ_OE[n] <= (level_reg == 3'(n)) & ~VME_IACK_MATCH;
         end
      end
   end

   // attention bits: set from VMEbus, cleared by CPU write-one, set wins
   always_ff @(posedge REF_CLK or negedge RST_B)
   begin
      if (!RST_B)
      begin
         low_attn_reg <= 1'b0;
         high_attn_reg <= 1'b0;
      end
      else
      begin
         if (VME_SET_LOW_ATTN && global_csr_set_live)
         begin
            low_attn_reg <= 1'b1;
         end
         else if (CLEAR_LOW_ATTN)
         begin
            low_attn_reg <= 1'b0;
         end
         if (VME_SET_HIGH_ATTN && global_csr_set_live)
         begin
            high_attn_reg <= 1'b1;
         end
         else if (CLEAR_HIGH_ATTN)
         begin
            high_attn_reg <= 1'b0;
         end
      end
   end

   // location monitors: access marks hit, acknowledge or rearm ends it
   always_ff @(posedge REF_CLK or negedge RST_B)
   begin
      if (!RST_B)
      begin
         mon0_hit_reg <= 1'b0;
         mon1_hit_reg <= 1'b0;
      end
      else
      begin
         if (VME_MON0_HIT && global_csr_set_live)
         begin
            mon0_hit_reg <= 1'b1;
         end
         else if (MON0_REARM || (local_ack && CPU_IACK_LEVEL == VUI_LVL_MON0))
         begin
            mon0_hit_reg <= 1'b0;
         end
         if (VME_MON1_HIT && global_csr_set_live)
         begin
            mon1_hit_reg <= 1'b1;
         end
         else if (MON1_REARM || (local_ack && CPU_IACK_LEVEL == VUI_LVL_MON1))
         begin
            mon1_hit_reg <= 1'b0;
         end
      end
   end

   // event latches for IACK completion and posted-write error
   always_ff @(posedge REF_CLK or negedge RST_B)
   begin
      if (!RST_B)
      begin
         ack_done_reg <= 1'b0;
         wp_err_reg <= 1'b0;
      end
      else
      begin
         if (VME_IACK_MATCH)
         begin
            ack_done_reg <= 1'b1;
         end
         else if (local_ack && CPU_IACK_LEVEL == VUI_LVL_ACK_DONE)
         begin
            ack_done_reg <= 1'b0;
         end
         if (POSTED_WR_BERR)
         begin
            wp_err_reg <= 1'b1;
         end
         else if (local_ack && CPU_IACK_LEVEL == VUI_LVL_WP_BERR)
         begin
            wp_err_reg <= 1'b0;
         end
      end
   end

   // bus error cause: newest only, read clears, new cause beats the clear
   always_ff @(posedge REF_CLK or negedge RST_B)
   begin
      if (!RST_B)
      begin
         cause_reg <= VUI_RST_CAUSE;
      end
      else if (VME_BERR_OWN)
      begin
         cause_reg <= 4'h4;
      end
      else if (VME_ACCESS_TIMEOUT)
      begin
         cause_reg <= 4'h2;
      end
      else if (LOCAL_TIMEOUT)
      begin
         cause_reg <= 4'h1;
      end
      else if (rd_take && CPU_ADDR == VUI_OFS_CAUSE)
      begin
         cause_reg <= VUI_RST_CAUSE;
      end
   end

   // read data mux, vector answer during local acknowledge
   always_comb
   begin
      rdata_next = 8'h00;
      if (local_ack)
      begin
         rdata_next = {vec_base_reg, CPU_IACK_LEVEL};
      end
      else
      begin
         case (CPU_ADDR)
            VUI_OFS_ENABLE: rdata_next = {enable_reg, 1'b0};
            VUI_OFS_VECTOR: rdata_next = {vec_base_reg, VUI_OFS_VECTOR[2:0]};
            VUI_OFS_LEVEL: rdata_next = {5'h00, level_reg};
            VUI_OFS_STATUS_ID: rdata_next = status_id_reg;
            VUI_OFS_CAUSE: rdata_next = {4'h0, cause_reg};
            VUI_OFS_GLOBAL_CSR_SET_BASE: rdata_next = {4'h0, global_csr_set_base_reg};
            default: rdata_next = 8'h00;
         endcase
      end
   end

   // registered read data, acknowledge and local request level
   always_ff @(posedge REF_CLK or negedge RST_B)
   begin
      if (!RST_B)
      begin
         CPU_RDATA <= 8'h00;
         CPU_ACK <= 1'b0;
         LOCAL_IRQ_LEVEL <= 3'h0;
      end
      else
      begin
         CPU_RDATA <= (CPU_SEL && !CPU_WR) ? rdata_next : 8'h00;
         CPU_ACK <= CPU_SEL;
         LOCAL_IRQ_LEVEL <= irq_level_next;
      end
   end

   // local CPU acknowledge sequence
   sequence ack_read_s;
      CPU_SEL && CPU_IACK && !CPU_WR;
   endsequence

   enable_cleared_a: assert property (@(posedge REF_CLK) disable iff (!RST_B)
      LOCAL_RESET |=> enable_reg == 7'h00)
      else $error("enable mask not cleared by reset");
   master_gate_a: assert property (@(posedge REF_CLK) disable iff (!RST_B)
      !MASTER_IRQ_EN |=> !LOCAL_IRQ_REQ)
      else $error("local request without master enable");
   level_top_a: assert property (@(posedge REF_CLK) disable iff (!RST_B)
      MASTER_IRQ_EN && active[7] |=> LOCAL_IRQ_LEVEL == 3'h7)
      else $error("highest level not presented");
   masked_source_a: assert property (@(posedge REF_CLK) disable iff (!RST_B)
      (enable_reg == 7'h00) |=> !LOCAL_IRQ_REQ)
      else $error("masked source raised request");
   ack_vector_a: assert property (@(posedge REF_CLK) disable iff (!RST_B)
      ack_read_s |=> CPU_RDATA == {$past(vec_base_reg), $past(CPU_IACK_LEVEL)})
      else $error("acknowledge vector wrong");
   vector_read_a: assert property (@(posedge REF_CLK) disable iff (!RST_B)
      rd_take && CPU_ADDR == VUI_OFS_VECTOR |=> CPU_RDATA[2:0] == 3'h3)
      else $error("vector read low bits not offset");
   irq_onehot_a: assert property (@(posedge REF_CLK) disable iff (!RST_B)
      level_reg != 3'h0 && !VME_IACK_MATCH |=> VME_IRQ_OE[$past(level_reg)] && $onehot(VME_IRQ_OE))
      else $error("wrong IRQ line driven");
   release_on_acknowledge_release_a: assert property (@(posedge REF_CLK) disable iff (!RST_B)
      VME_IACK_MATCH |=> level_reg == 3'h0 && VME_IRQ_OE == 7'h00 && ack_done_reg)
      else $error("request not released on acknowledge");
   cause_clear_a: assert property (@(posedge REF_CLK) disable iff (!RST_B)
      rd_take && CPU_ADDR == VUI_OFS_CAUSE && !VME_BERR_OWN && !VME_ACCESS_TIMEOUT
      && !LOCAL_TIMEOUT |=> cause_reg == VUI_RST_CAUSE)
      else $error("cause not cleared by read");
   cause_newest_a: assert property (@(posedge REF_CLK) disable iff (!RST_B)
      LOCAL_TIMEOUT && !VME_BERR_OWN && !VME_ACCESS_TIMEOUT |=> cause_reg == 4'h1)
      else $error("older cause kept");
   global_csr_set_off_a: assert property (@(posedge REF_CLK) disable iff (!RST_B)
      global_csr_set_base_reg == VUI_GLOBAL_CSR_SET_OFF |-> !GLOBAL_CSR_SET_HIT)
      else $error("disabled window responded");
   attn_hold_a: assert property (@(posedge REF_CLK) disable iff (!RST_B)
      low_attn_reg && !CLEAR_LOW_ATTN |=> low_attn_reg)
      else $error("low attention dropped without clear");

endmodule // vui_utility_irq

// ### pkg/vui_pkg.sv
// constants and types for the utility interrupt handler and interrupter
package vui_pkg;
   // register byte addresses on the local bus
   localparam logic [31:0] VUI_OFS_ENABLE = 32'hFFFE2011;
   localparam logic [31:0] VUI_OFS_VECTOR = 32'hFFFE2013;
   localparam logic [31:0] VUI_OFS_LEVEL = 32'hFFFE2015;
   localparam logic [31:0] VUI_OFS_STATUS_ID = 32'hFFFE2017;
   localparam logic [31:0] VUI_OFS_CAUSE = 32'hFFFE2019;
   localparam logic [31:0] VUI_OFS_GLOBAL_CSR_SET_BASE = 32'hFFFE201B;
   // utility levels, equal to enable bit position and source identifier
   localparam logic [2:0] VUI_LVL_LOW_ATTN = 3'h1;
   localparam logic [2:0] VUI_LVL_MON0 = 3'h2;
   localparam logic [2:0] VUI_LVL_ACK_DONE = 3'h3;
   localparam logic [2:0] VUI_LVL_MON1 = 3'h4;
   localparam logic [2:0] VUI_LVL_HIGH_ATTN = 3'h5;
   localparam logic [2:0] VUI_LVL_SYSFAIL = 3'h6;
   localparam logic [2:0] VUI_LVL_WP_BERR = 3'h7;
   // field positions
   localparam int VUI_VEC_BASE_LSB = 3;
   localparam int VUI_ENABLE_LSB = 1;
   localparam int VUI_SHORT_REG_LSB = 1;
   localparam int VUI_SHORT_BASE_LSB = 4;
   localparam int VUI_SHORT_HIGH_LSB = 8;
   // values after reset
   localparam logic [7:1] VUI_RST_ENABLE = 7'h00;
   localparam logic [4:0] VUI_RST_VEC_BASE = 5'h00;
   localparam logic [2:0] VUI_RST_LEVEL = 3'h0;
   localparam logic [7:0] VUI_RST_STATUS_ID = 8'h0F;
   localparam logic [3:0] VUI_RST_GLOBAL_CSR_SET_BASE = 4'hF;
   localparam logic [3:0] VUI_GLOBAL_CSR_SET_OFF = 4'hF;
   localparam logic [7:0] VUI_SHORT_HIGH_ZERO = 8'h00;
   // bus error cause bits, newest cause only
   typedef struct packed {
      logic unused3;
      logic vme_bus_error_flag;
      logic vme_access_timeout_flag;
      logic local_timeout_flag;
   } vui_cause_type;
   localparam vui_cause_type VUI_RST_CAUSE = 4'h0;
   // VMEbus-side acknowledge request
   typedef struct packed {
      logic hit;
      logic [2:0] level;
   } vui_vme_iack_type;
endpackage : vui_pkg

// ### tb/vui_utility_irq_tb.sv
// self-checking bench for the utility interrupt handler and interrupter
`timescale 1ns/1ps
module vui_utility_irq_tb;
   import vui_pkg::*;
   logic clk = 1'b0, rst_b = 1'b0, sel = 1'b0, wr = 1'b0, iack = 1'b0, bad = 1'b0;
   logic [15:0] ev = 16'h0000;
   logic [15:0] sadr = 16'h0000;
   logic [31:0] adr = 32'h00000000;
   logic [7:0] wd = 8'h00;
   logic [2:0] lvl = 3'h0;
   logic [3:0] lat = 4'h0;
   logic [7:0] rd, sid;
   logic [7:1] oe;
   logic [2:0] ilv, gsel;
   logic [1:0] attn, mon;
   logic ack, irq, match, ghit;
   vui_vme_iack_type viack;
   int err_count = 0, n_tests = 0, n_match = 0, cyc = 0, m, n, k;
   // ev bits: 0 lrst 1/2 set attn 3/4 clr attn 5/6 mon hit 7/8 rearm
   // 9 sysfail 10 wp berr 11-13 causes 14 master enable 15 short select
   vui_utility_irq dut (.REF_CLK(clk), .RST_B(rst_b), .LOCAL_RESET(ev[0]), .CPU_SEL(sel),
      .CPU_WR(wr), .CPU_ADDR(adr), .CPU_WDATA(wd), .CPU_IACK(iack), .CPU_IACK_LEVEL(lvl),
      .CPU_RDATA(rd), .CPU_ACK(ack), .MASTER_IRQ_EN(ev[14]), .LOCAL_IRQ_REQ(irq),
      .LOCAL_IRQ_LEVEL(ilv), .VME_SET_LOW_ATTN(ev[1]), .VME_SET_HIGH_ATTN(ev[2]),
      .CLEAR_LOW_ATTN(ev[3]), .CLEAR_HIGH_ATTN(ev[4]), .ATTN_BITS(attn),
      .VME_MON0_HIT(ev[5]), .VME_MON1_HIT(ev[6]), .MON0_REARM(ev[7]), .MON1_REARM(ev[8]),
      .MON_FLAGS(mon), .SYSFAIL_ACTIVE(ev[9]), .POSTED_WR_BERR(ev[10]),
      .LOCAL_TIMEOUT(ev[11]), .VME_ACCESS_TIMEOUT(ev[12]), .VME_BERR_OWN(ev[13]),
      .VME_IACK(viack), .VME_IACK_MATCH(match), .VME_IRQ_OE(oe), .VME_STATUS_ID(sid),
      .VME_SHORT_SEL(ev[15]), .VME_SHORT_ADDR(sadr), .GLOBAL_CSR_SET_HIT(ghit), .GLOBAL_CSR_SET_REG_SEL(gsel));
   vui_vme_handler hnd (.clk(clk), .rst_b(rst_b), .irq_oe(oe), .lat(lat), .bad(bad),
      .iack(viack));
   // clock and answered IACK cycles
   always #20 clk = ~clk;
   always @(posedge clk)
      if (viack.hit && match)
         n_match <= n_match + 1;
   // hang guard
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 5000)
      begin
         err_count++;
         final_report();
      end
   end
   task automatic final_report();
      if (err_count == 0 && n_tests > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic chk(input logic [15:0] s, input logic [15:0] e);
      n_tests++;
      if (s !== e)
      begin
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
         err_count++;
      end
   endtask
   task automatic tick(input int c);
      repeat (c) @(negedge clk);
   endtask
   task automatic pulse(input int i);
      ev[i] = 1'b1;
      tick(1);
      ev[i] = 1'b0;
      tick(1);
   endtask
   // one access; the answer stands in the cycle after the select
   task automatic cpu(input logic w, input logic [7:0] a, input logic [7:0] d,
      input logic ia, input logic [2:0] l);
      sel = 1'b1;
      wr = w;
      iack = ia;
      lvl = l;
      adr = {24'hFFFE20, a};
      wd = d;
      tick(1);
      sel = 1'b0;
      chk(ack, 1'b1);
   endtask
   task automatic rdc(input logic [7:0] a, input logic [7:0] e);
      cpu(1'b0, a, 8'h00, 1'b0, 3'h0);
      chk(rd, e);
   endtask
   task automatic wrr(input logic [7:0] a, input logic [7:0] d);
      cpu(1'b1, a, d, 1'b0, 3'h0);
   endtask
   task automatic await_clear();
      for (k = 0; k < 40 && oe !== 7'h00; k++)
         tick(1);
      tick(2);
   endtask
   task automatic t_reset();
      rdc(8'h11, 8'h00);
      rdc(8'h13, 8'h03);
      rdc(8'h15, 8'h00);
      rdc(8'h17, 8'h0F);
      rdc(8'h19, 8'h00);
      rdc(8'h1B, 8'h0F);
      wrr(8'h12, 8'hFF);
      rdc(8'h12, 8'h00);
      chk({mon, oe}, {2'h3, 7'h00});
   endtask
   task automatic t_global_csr_set();
      ev[15] = 1'b1;
      for (n = 0; n < 16; n++)
      begin
         wrr(8'h1B, 8'(n));
         sadr = {8'h00, 4'(n), 4'hE};
         tick(1);
         chk({ghit, gsel}, {n != 15, 3'h7});
         sadr[8] = 1'b1;
         tick(1);
         chk(ghit, 1'b0);
      end
      ev[15] = 1'b0;
      pulse(1);
      tick(1);
      chk({attn, ilv}, 5'h00);
   endtask
   task automatic t_prio();
      wrr(8'h1B, 8'h00);
      wrr(8'h11, 8'hFF);
      rdc(8'h11, 8'hFE);
      ev[9] = 1'b1;
      tick(2);
      chk(ilv, 3'h6);
      pulse(1);
      pulse(2);
      tick(1);
      chk({attn, ilv}, {2'h3, 3'h6});
      ev[9] = 1'b0;
      tick(2);
      chk(ilv, 3'h5);
      wrr(8'h11, 8'hDE);
      tick(2);
      chk(ilv, 3'h1);
      ev[14] = 1'b0;
      tick(2);
      chk({irq, ilv}, 4'h0);
      ev[14] = 1'b1;
      pulse(3);
      tick(1);
      chk({attn, ilv}, {2'h2, 3'h0});
      pulse(4);
      wrr(8'h11, 8'hBE);
      ev[9] = 1'b1;
      tick(2);
      chk({attn, ilv}, 5'h00);
      ev[9] = 1'b0;
   endtask
   task automatic t_mon();
      wrr(8'h11, 8'h04);
      pulse(5);
      tick(1);
      chk({mon, ilv}, {2'h2, 3'h2});
      cpu(1'b0, 8'h13, 8'h00, 1'b1, 3'h2);
      chk(rd, 8'h02);
      tick(2);
      chk({mon, ilv}, {2'h3, 3'h0});
      pulse(6);
      tick(1);
      chk({mon, ilv}, {2'h1, 3'h0});
      wrr(8'h11, 8'h10);
      tick(2);
      chk(ilv, 3'h4);
      pulse(8);
      tick(1);
      chk({mon, ilv}, {2'h3, 3'h0});
   endtask
   task automatic t_wperr();
      wrr(8'h13, 8'hAF);
      wrr(8'h11, 8'h80);
      ev[10] = 1'b1;
      tick(1);
      ev[10] = 1'b0;
      chk(ilv, 3'h0);
      tick(1);
      chk({irq, ilv}, {1'b1, 3'h7});
      cpu(1'b0, 8'h13, 8'h00, 1'b1, 3'h7);
      chk(rd, 8'hAF);
      tick(1);
      chk(ilv, 3'h0);
      rdc(8'h13, 8'hAB);
   endtask
   task automatic t_vme();
      wrr(8'h17, 8'h5A);
      chk(sid, 8'h5A);
      wrr(8'h11, 8'h08);
      for (n = 1; n < 8; n++)
      begin
         lat = 4'(n + 3);
         m = n_match;
         wrr(8'h15, 8'(n));
         tick(1);
         chk(oe, 7'(7'h01 << (n - 1)));
         rdc(8'h15, 8'(n));
         await_clear();
         chk(16'(n_match - m), 16'h0001);
         rdc(8'h15, 8'h00);
         chk(ilv, 3'h3);
         cpu(1'b0, 8'h13, 8'h00, 1'b1, 3'h3);
         tick(2);
      end
      bad = 1'b1;
      lat = 4'h0;
      m = n_match;
      wrr(8'h15, 8'h03);
      tick(8);
      chk({oe, 8'(n_match - m)}, {7'h04, 8'h00});
      bad = 1'b0;
      await_clear();
      chk({oe, 8'(n_match - m)}, {7'h00, 8'h01});
   endtask
   task automatic t_cause();
      pulse(11);
      rdc(8'h19, 8'h01);
      rdc(8'h19, 8'h00);
      pulse(11);
      pulse(12);
      rdc(8'h19, 8'h02);
      pulse(13);
      rdc(8'h19, 8'h04);
      rdc(8'h19, 8'h00);
   endtask
   task automatic t_lrst();
      pulse(0);
      rdc(8'h11, 8'h00);
      rdc(8'h13, 8'h03);
      chk(sid, 8'h5A);
   endtask
   // main sequence
   initial
   begin
      tick(5);
      rst_b = 1'b1;
      ev[14] = 1'b1;
      tick(1);
      t_reset();
      t_global_csr_set();
      t_prio();
      t_mon();
      t_wperr();
      t_vme();
      t_cause();
      t_lrst();
      final_report();
   end
endmodule // vui_utility_irq_tb

// ### tb/vui_vme_handler.sv
// behavioural VMEbus interrupt handler that answers the block's IRQ lines
`timescale 1ns/1ps
module vui_vme_handler
   import vui_pkg::*;
(
   input wire logic clk,
   input wire logic rst_b,
   input wire logic [7:1] irq_oe,
   input wire logic [3:0] lat,
   input wire logic bad,
   output vui_vme_iack_type iack
);
   logic [3:0] cnt_reg;
   logic [2:0] top_lvl;
   // highest IRQ line being driven
   always_comb
   begin
      top_lvl = 3'h0;
      for (int i = 1; i < 8; i++)
         if (irq_oe[i])
            top_lvl = 3'(i);
   end
   // wait lat cycles, then one IACK cycle; level lines toggle while idle
   always_ff @(negedge clk or negedge rst_b)
      if (!rst_b)
      begin
         iack <= '{hit: 1'b0, level: 3'h5};
         cnt_reg <= 4'h0;
      end
      else if (iack.hit || irq_oe == 7'h00 || cnt_reg < lat)
      begin
         iack <= '{hit: 1'b0, level: ~iack.level};
         cnt_reg <= (iack.hit || irq_oe == 7'h00) ? 4'h0 : cnt_reg + 4'h1;
      end
      else
         iack <= '{hit: 1'b1, level: bad ? top_lvl + 3'h1 : top_lvl}; // wrong level on demand
endmodule // vui_vme_handler
